// file: logic/dpsram_counter.sv
// Burst address counter with wrap mask, retransmit and wrap flag.
// Assumes controls are sampled on the rising clock edge.
`timescale 1ns/100ps
module dpsram_counter
	import dpsram_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          rst_b,
	// Counter controls
	input  wire logic          address_load_strobe_n,
	input  wire logic          counter_advance_n,
	input  wire logic          counter_clear_n,
	input  wire logic          counter_or_wrapmask_select,
	input  wire logic [AW-1:0] ext_addr,
	// Results
	output logic      [AW-1:0] cnt_nxt,
	output logic      [AW-1:0] readback_value,
	output logic               readback_req,
	output logic               wrap_flag_n
);
	cnt_mode_type  mode;
	logic [AW-1:0] cnt_r;
	logic [AW-1:0] mask_r;
	logic [AW-1:0] base_r;
	logic [AW-1:0] inc_val;
	logic          at_max;
	logic          wrap_r;

	// Mode decode, clear first
	always_comb begin
		if (!counter_clear_n)
			mode = CNT_CLEAR;
		else if (!address_load_strobe_n && !counter_advance_n)
			mode = counter_or_wrapmask_select ? CNT_LOAD : CNT_MASK_LOAD;
		else if (!address_load_strobe_n)
			mode = CNT_READBACK;
		else if (!counter_advance_n)
			mode = CNT_INC;
		else
			mode = CNT_HOLD;
	end

	// retransmit on wrap
	// Only bits set in the mask count; at the top the loaded start comes back
	assign at_max  = ((cnt_r & mask_r) == mask_r);
	assign inc_val = at_max ? base_r : ((cnt_r & ~mask_r) | ((cnt_r + 1'b1) & mask_r));

	// Next address, used by the access in the same cycle
	always_comb begin
		case (mode)
			CNT_CLEAR: cnt_nxt = {AW{CNT_RESET_BIT}};
			CNT_LOAD:  cnt_nxt = ext_addr;
			CNT_INC:   cnt_nxt = inc_val;
			default:   cnt_nxt = cnt_r;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r  <= {AW{CNT_RESET_BIT}};
			base_r <= {AW{CNT_RESET_BIT}};
		end else begin
			cnt_r <= cnt_nxt;
			if (mode == CNT_LOAD || mode == CNT_CLEAR)
				base_r <= cnt_nxt;
		end
	end

	// Wrap mask register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			mask_r <= {AW{MASK_RESET_BIT}};
		else if (mode == CNT_MASK_LOAD)
			mask_r <= ext_addr;
	end

	// wrap flag
	// Set on reaching the top; any other counter change clears it
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			wrap_r <= 1'b0;
		else if (mode == CNT_INC)
			wrap_r <= ((inc_val & mask_r) == mask_r);
		else if (mode != CNT_HOLD && mode != CNT_READBACK)
			wrap_r <= 1'b0;
	end

	assign wrap_flag_n = ~wrap_r;

	assign readback_req   = (mode == CNT_READBACK);
	assign readback_value = counter_or_wrapmask_select ? cnt_r : mask_r;

	chk_counter_load: assert property (@(posedge clock) disable iff (!rst_b)
		(mode == CNT_LOAD) |=> (cnt_r == $past(ext_addr)))
		else $error("counter did not load address");
	chk_counter_clear: assert property (@(posedge clock) disable iff (!rst_b)
		(mode == CNT_CLEAR) |=> (cnt_r == '0))
		else $error("counter did not clear");
	chk_wrap_retransmit: assert property (@(posedge clock) disable iff (!rst_b)
		(mode == CNT_INC && at_max) |=> (cnt_r == $past(base_r)))
		else $error("counter did not return to start");
	chk_wrap_flag_set: assert property (@(posedge clock) disable iff (!rst_b)
		(mode == CNT_INC && ((inc_val & mask_r) == mask_r)) |=> !wrap_flag_n)
		else $error("wrap flag not raised");
endmodule // dpsram_counter

// file: logic/dpsram_mem.sv
// Memory core with two ports, byte-lane writes and registered read data.
// Assumes the caller sends at most one write per port per clock edge.
`timescale 1ns/100ps
module dpsram_mem
	import dpsram_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W,
	parameter int NL = LANES
) (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	// Access per port
	input  wire logic [1:0]             we,
	input  wire logic [1:0][NL-1:0]     lane_we,
	input  wire logic [1:0][AW-1:0]     addr,
	input  wire logic [1:0][DW-1:0]     wdata,
	// Read data per port
	output logic      [1:0][DW-1:0]     rdata_r
);
	localparam int LW = DW / NL;

	logic [DW-1:0] mem [0:(2**AW)-1];

	// Byte-lane writes; a same-address clash between ports is undefined
	always_ff @(posedge clock) begin
		for (int p = 0; p < 2; p++) begin
			for (int l = 0; l < NL; l++) begin
				if (we[p] && lane_we[p][l])
					mem[addr[p]][l*LW +: LW] <= wdata[p][l*LW +: LW];
			end
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_rd
		localparam int Q = 1 - p;
		logic [DW-1:0] fwd;

		// forward new data
		// Forwarding makes the other port's write visible in the same cycle
		always_comb begin
			fwd = mem[addr[p]];
			for (int l = 0; l < NL; l++) begin
				if (we[Q] && lane_we[Q][l] && (addr[Q] == addr[p]))
					fwd[l*LW +: LW] = wdata[Q][l*LW +: LW];
			end
		end

		// Read register
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b)
				rdata_r[p] <= {DW{DATA_RESET_BIT}};
			else
				rdata_r[p] <= fwd;
		end

		chk_collision_fwd: assert property (@(posedge clock) disable iff (!rst_b)
			(we[Q] && (&lane_we[Q]) && (addr[Q] == addr[p])) |=> (rdata_r[p] == $past(wdata[Q])))
			else $error("collision read missed new data");
	end
endmodule // dpsram_mem

// file: logic/dpsram_pkg.sv
// Shared constants and types for the dual-port SRAM port logic.
// Assumes both ports and the memory core run on one common clock.
package dpsram_pkg;

	// Geometry of the largest-density variant
	localparam int ADDR_W = 18;
	localparam int DATA_W = 36;
	localparam int LANES  = 4;

	// Port indices
	localparam int PORT_LEFT  = 0;
	localparam int PORT_RIGHT = 1;

	// Mailbox locations, given as distance below the top address
	localparam int MBX_RIGHT_OFS = 0;
	localparam int MBX_LEFT_OFS  = 1;

	// Values after reset
	localparam logic CNT_RESET_BIT  = 1'b0;
	localparam logic MASK_RESET_BIT = 1'b1;
	localparam logic DATA_RESET_BIT = 1'b0;

	// Clock period, for reference by timing checks
	localparam int CLOCK_PERIOD_NS = 100;

	// Burst counter operation decoded from the counter controls
	typedef enum logic [5:0] {
		CNT_HOLD      = 6'h01,
		CNT_LOAD      = 6'h02,
		CNT_INC       = 6'h04,
		CNT_CLEAR     = 6'h08,
		CNT_MASK_LOAD = 6'h10,
		CNT_READBACK  = 6'h20
	} cnt_mode_type;

	// Access held in the pipeline stage after the sampling edge
	typedef enum logic [3:0] {
		OP_IDLE  = 4'h1,
		OP_READ  = 4'h2,
		OP_WRITE = 4'h4,
		OP_NOP   = 4'h8
	} port_op_type;

endpackage

// file: logic/dpsram_port_logic.sv
// Port-side cycle logic of a pipelined two-port SRAM: selects, pipeline,
// turnaround, burst counters, address readback, wrap flags and mailboxes.
// Assumes both ports share one clock; pin inputs are synchronous except
// the output gate, and the bench resolves the two-way pins from enables.
`timescale 1ns/100ps
module dpsram_port_logic
	import dpsram_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W,
	parameter int NL = LANES
) (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	// Selects and direction, index 0 left port, 1 right port
	input  wire logic [1:0]             select_low_input_n,
	input  wire logic [1:0]             select_high_input,
	input  wire logic [1:0]             read_not_write,
	input  wire logic [1:0]             output_gate_n,
	input  wire logic [1:0][NL-1:0]     byte_lane_enables_n,
	// Burst counter controls
	input  wire logic [1:0]             address_load_strobe_n,
	input  wire logic [1:0]             counter_advance_n,
	input  wire logic [1:0]             counter_clear_n,
	input  wire logic [1:0]             counter_or_wrapmask_select,
	// Address pins, two-way
	input  wire logic [1:0][AW-1:0]     address_in,
	output logic      [1:0][AW-1:0]     address_out,
	output logic      [1:0]             address_oe_n,
	// Data pins, two-way
	input  wire logic [1:0][DW-1:0]     data_in,
	output logic      [1:0][DW-1:0]     data_out,
	output logic      [1:0]             data_oe_n,
	// Flags
	output logic      [1:0]             wrap_flag_n,
	output logic      [1:0]             mailbox_flag_n
);
	localparam logic [AW-1:0] TOP_ADDR = {AW{1'b1}};

	// Combined select and decoded requests
	logic        [1:0]         cs;
	logic        [1:0]         rb_req;
	logic        [1:0]         rb_go;
	logic        [1:0]         nop_cond;
	logic        [1:0][AW-1:0] cnt_nxt;
	logic        [1:0][AW-1:0] rb_value;
	logic        [1:0][AW-1:0] mbx_addr;

	// Pipeline stage between the sampling edge and the memory access
	port_op_type               op_r [2];
	port_op_type               op_nxt [2];
	logic        [1:0][AW-1:0] addr_q_r;
	logic        [1:0][DW-1:0] wdata_r;
	logic        [1:0][NL-1:0] lanes_r;
	logic        [1:0]         drive_r;
	logic        [1:0]         addr_drive_r;
	logic        [1:0][AW-1:0] addr_out_r;
	logic        [1:0]         flag_r;

	// Memory access signals
	logic        [1:0]         mem_we;
	logic        [1:0][NL-1:0] mem_lane_we;

	for (genvar p = 0; p < 2; p++) begin : g_port
		localparam int Q = 1 - p;

		assign cs[p] = !select_low_input_n[p] && select_high_input[p];

		// Burst counter of this port
		dpsram_counter #(
			.AW (AW)
		) u_counter (
			.clock                      (clock),
			.rst_b                      (rst_b),
			.address_load_strobe_n      (address_load_strobe_n[p]),
			.counter_advance_n          (counter_advance_n[p]),
			.counter_clear_n            (counter_clear_n[p]),
			.counter_or_wrapmask_select (counter_or_wrapmask_select[p]),
			.ext_addr                   (address_in[p]),
			.cnt_nxt                    (cnt_nxt[p]),
			.readback_value             (rb_value[p]),
			.readback_req               (rb_req[p]),
			.wrap_flag_n                (wrap_flag_n[p])
		);

		// Readback needs the port selected; no memory access happens then
		assign rb_go[p] = cs[p] && rb_req[p];

		// write turnaround
		// The bus still carries read data, so the first write is dropped
		assign nop_cond[p] = (op_r[p] == OP_READ) && !output_gate_n[p];

		// Operation decode from the sampled controls
		always_comb begin
			if (!cs[p] || rb_go[p])
				op_nxt[p] = OP_IDLE;
			else if (read_not_write[p])
				op_nxt[p] = OP_READ;
			else if (nop_cond[p])
				op_nxt[p] = OP_NOP;
			else
				op_nxt[p] = OP_WRITE;
		end

		// clocked sampling
		// Address, data and lanes are captured on every edge
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) begin
				op_r[p]     <= OP_IDLE;
				addr_q_r[p] <= '0;
				wdata_r[p]  <= '0;
				lanes_r[p]  <= '0;
			end else begin
				op_r[p]     <= op_nxt[p];
				addr_q_r[p] <= cnt_nxt[p];
				wdata_r[p]  <= data_in[p];
				lanes_r[p]  <= ~byte_lane_enables_n[p];
			end
		end

		assign mem_we[p]      = (op_r[p] == OP_WRITE);
		assign mem_lane_we[p] = lanes_r[p];

		// output drive
		// Drive follows the access sampled one cycle earlier
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b)
				drive_r[p] <= 1'b0;
			else
				drive_r[p] <= (op_r[p] == OP_READ);
		end

		assign data_oe_n[p] = !(drive_r[p] && !output_gate_n[p]);

		// address readback
		// Drivers switch on after the sampling edge and drop after the next
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) begin
				addr_drive_r[p] <= 1'b0;
				addr_out_r[p]   <= '0;
			end else begin
				addr_drive_r[p] <= rb_go[p];
				addr_out_r[p]   <= rb_value[p];
			end
		end

		assign address_out[p]  = addr_out_r[p];
		assign address_oe_n[p] = !addr_drive_r[p];

		assign mbx_addr[p] = (p == PORT_RIGHT) ? TOP_ADDR - AW'(MBX_RIGHT_OFS)
		                                       : TOP_ADDR - AW'(MBX_LEFT_OFS);

		// mailbox flag
		// Writer sets, owner's read clears; a set in the same cycle wins
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b)
				flag_r[p] <= 1'b0;
			else if (op_r[Q] == OP_WRITE && addr_q_r[Q] == mbx_addr[p] && |lanes_r[Q])
				flag_r[p] <= 1'b1;
			else if (op_r[p] == OP_READ && addr_q_r[p] == mbx_addr[p] && |lanes_r[p])
				flag_r[p] <= 1'b0;
		end

		assign mailbox_flag_n[p] = !flag_r[p];

		chk_select_combine: assert property (@(posedge clock) disable iff (!rst_b)
			(op_r[p] != OP_IDLE) |-> $past(!select_low_input_n[p] && select_high_input[p]))
			else $error("access taken without combined select");

		chk_read_latency: assert property (@(posedge clock) disable iff (!rst_b)
			(cs[p] && read_not_write[p] && !rb_go[p]) |=> ##1 drive_r[p])
			else $error("read data not driven after second edge");

		chk_gate_async: assert property (@(posedge clock) disable iff (!rst_b)
			output_gate_n[p] |-> data_oe_n[p])
			else $error("data driven while output gate high");

		chk_deselect_float: assert property (@(posedge clock) disable iff (!rst_b)
			!cs[p] |=> ##1 data_oe_n[p])
			else $error("data still driven after deselect");

		chk_prev_cycle_state: assert property (@(posedge clock) disable iff (!rst_b)
			(cs[p] && !read_not_write[p]) |=> ##1 data_oe_n[p])
			else $error("data driven after a sampled write");

		chk_write_turnaround: assert property (@(posedge clock) disable iff (!rst_b)
			(cs[p] && !rb_go[p] && !read_not_write[p] && nop_cond[p]) ##1
			(cs[p] && !rb_go[p] && !read_not_write[p])
			|-> (op_r[p] == OP_NOP) ##1 (op_r[p] == OP_WRITE && !mem_we[p] == 1'b0))
			else $error("write turnaround not one no-op cycle");

		chk_readback_drive: assert property (@(posedge clock) disable iff (!rst_b)
			rb_go[p] |=> (!address_oe_n[p] && address_out[p] == $past(rb_value[p])))
			else $error("readback value not driven");

		chk_readback_release: assert property (@(posedge clock) disable iff (!rst_b)
			!rb_go[p] |=> address_oe_n[p])
			else $error("address drivers not released");

		chk_mailbox_set: assert property (@(posedge clock) disable iff (!rst_b)
			(op_r[Q] == OP_WRITE && addr_q_r[Q] == mbx_addr[p] && |lanes_r[Q])
			|=> !mailbox_flag_n[p])
			else $error("mailbox flag not set by write");

		chk_mailbox_clear: assert property (@(posedge clock) disable iff (!rst_b)
			(op_r[p] == OP_READ && addr_q_r[p] == mbx_addr[p] && |lanes_r[p] &&
			 !(op_r[Q] == OP_WRITE && addr_q_r[Q] == mbx_addr[p] && |lanes_r[Q]))
			|=> mailbox_flag_n[p])
			else $error("mailbox flag not cleared by read");

		chk_store_lanes: assert property (@(posedge clock) disable iff (!rst_b)
			mem_we[p] |-> (mem_lane_we[p] == ~$past(byte_lane_enables_n[p])))
			else $error("store lanes differ from sampled enables");
	end

	// Shared memory core; read data leave straight from its register
	dpsram_mem #(
		.AW (AW),
		.DW (DW),
		.NL (NL)
	) u_mem (
		.clock   (clock),
		.rst_b   (rst_b),
		.we      (mem_we),
		.lane_we (mem_lane_we),
		.addr    (addr_q_r),
		.wdata   (wdata_r),
		.rdata_r (data_out)
	);
endmodule // dpsram_port_logic

// file: sim/dpsram_host_pins.sv
// Host pin model for one port: resolves the two-way address and data pins.
// Assumes the bench supplies the host drive values and enables each cycle.
`timescale 1ns/100ps
module dpsram_host_pins
	import dpsram_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	// Clock
	input  wire logic          clock,
	// Host drive
	input  wire logic [AW-1:0] host_addr,
	input  wire logic          host_addr_en,
	input  wire logic [DW-1:0] host_data,
	input  wire logic          host_data_en,
	// Device drive
	input  wire logic [AW-1:0] address_out,
	input  wire logic          address_oe_n,
	input  wire logic [DW-1:0] data_out,
	input  wire logic          data_oe_n,
	// Resolved pins
	output logic      [AW-1:0] address_pin,
	output logic      [DW-1:0] data_pin
);
	logic [AW-1:0] addr_last_r;
	logic [DW-1:0] data_last_r;

	// Last pin levels, so a released pin shows their inverse
	always_ff @(posedge clock) begin
		addr_last_r <= address_pin;
		data_last_r <= data_pin;
	end

	// address hand-over
	// Two drivers at once give unknown, so a late release corrupts the pin
	always_comb begin
		if (!address_oe_n && host_addr_en)
			address_pin = 'x;
		else if (!address_oe_n)
			address_pin = address_out;
		else if (host_addr_en)
			address_pin = host_addr;
		else
			address_pin = ~addr_last_r;
	end

	always_comb begin
		if (!data_oe_n && host_data_en)
			data_pin = 'x;
		else if (!data_oe_n)
			data_pin = data_out;
		else if (host_data_en)
			data_pin = host_data;
		else
			data_pin = ~data_last_r;
	end
endmodule // dpsram_host_pins

// file: sim/test_dual_port_sram_port_logic.sv
// Self-checking bench for the dual-port SRAM port logic.
// Assumes one shared clock and the host pin model in dpsram_host_pins.
`timescale 1ns/100ps
module test_dual_port_sram_port_logic
	import dpsram_pkg::*;
;
	typedef struct {
		logic        cs;
		logic        hi;
		logic        rw;
		logic        load_n;
		logic        adv_n;
		logic        clr_n;
		logic        cms;
		logic [3:0]  lanes_n;
		logic [17:0] addr;
		logic        a_en;
		logic [35:0] data;
		logic        d_en;
	} req_type;

	logic                 clock;
	logic                 rst_b;
	logic [1:0]           select_low_input_n;
	logic [1:0]           select_high_input;
	logic [1:0]           read_not_write;
	logic [1:0]           output_gate_n;
	logic [1:0][3:0]      byte_lane_enables_n;
	logic [1:0]           address_load_strobe_n;
	logic [1:0]           counter_advance_n;
	logic [1:0]           counter_clear_n;
	logic [1:0]           counter_or_wrapmask_select;
	logic [1:0][17:0]     address_in;
	logic [1:0][17:0]     address_out;
	logic [1:0]           address_oe_n;
	logic [1:0][35:0]     data_in;
	logic [1:0][35:0]     data_out;
	logic [1:0]           data_oe_n;
	logic [1:0]           wrap_flag_n;
	logic [1:0]           mailbox_flag_n;
	logic [1:0][17:0]     host_addr;
	logic [1:0]           host_addr_en;
	logic [1:0][35:0]     host_data;
	logic [1:0]           host_data_en;
	req_type              nx [2];
	logic [35:0]          mem [int];
	logic [17:0]          a;
	logic [17:0]          exp_cnt;
	int                   bad_count;
	int                   check_count;

	dpsram_port_logic DUT (.*);

	// Host pin models, one per port
	for (genvar p = 0; p < 2; p++) begin : g_host
		dpsram_host_pins host (.clock(clock), .host_addr(host_addr[p]),
			.host_addr_en(host_addr_en[p]), .host_data(host_data[p]),
			.host_data_en(host_data_en[p]), .address_out(address_out[p]),
			.address_oe_n(address_oe_n[p]), .data_out(data_out[p]),
			.data_oe_n(data_oe_n[p]), .address_pin(address_in[p]),
			.data_pin(data_in[p]));
	end

	// Clock, 100 ns period
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Quiet request: host released, counter held
	function automatic req_type idle_req();
		req_type r;
		r = '{cs: 0, hi: 1, rw: 1, load_n: 1, adv_n: 1, clr_n: 1, cms: 1,
			lanes_n: 0, addr: 0, a_en: 0, data: 0, d_en: 0};
		return r;
	endfunction

	// Access with address load on the same edge
	function automatic req_type acc(bit w, logic [17:0] ad, logic [35:0] d, logic [3:0] ln);
		req_type r;
		r = idle_req();
		r.cs = 1'b1;
		r.rw = !w;
		r.load_n = 1'b0;
		r.adv_n = 1'b0;
		r.addr = ad;
		r.a_en = 1'b1;
		r.data = d;
		r.d_en = w;
		r.lanes_n = ln;
		return r;
	endfunction

	// Counter operation; host drives address only for loads
	function automatic req_type ctl(logic ld, logic ad, logic cm, logic [17:0] v, logic c);
		req_type r;
		r = idle_req();
		r.cs = c;
		r.load_n = ld;
		r.adv_n = ad;
		r.cms = cm;
		r.addr = v;
		r.a_en = !ld && !ad;
		return r;
	endfunction

	// Reference memory, byte lanes of 9 bits
	function automatic void mwr(int ad, logic [35:0] d, logic [3:0] ln);
		logic [35:0] v;
		v = mem.exists(ad) ? mem[ad] : '0;
		for (int l = 0; l < 4; l++)
			if (!ln[l])
				v[9*l +: 9] = d[9*l +: 9];
		mem[ad] = v;
	endfunction

	// Apply the pending requests and return both ports to quiet
	task automatic drive();
		for (int p = 0; p < 2; p++) begin
			select_low_input_n[p] = !nx[p].cs;
			select_high_input[p] = nx[p].hi;
			read_not_write[p] = nx[p].rw;
			byte_lane_enables_n[p] = nx[p].lanes_n;
			address_load_strobe_n[p] = nx[p].load_n;
			counter_advance_n[p] = nx[p].adv_n;
			counter_clear_n[p] = nx[p].clr_n;
			counter_or_wrapmask_select[p] = nx[p].cms;
			host_addr[p] = nx[p].addr;
			host_addr_en[p] = nx[p].a_en;
			host_data[p] = nx[p].data;
			host_data_en[p] = nx[p].d_en;
			nx[p] = idle_req();
		end
	endtask

	task automatic tick();
		@(posedge clock);
		#1;
		drive();
	endtask

	task automatic chk(logic [35:0] got, logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(int p, logic [17:0] ad, logic [35:0] d, logic [3:0] ln);
		nx[p] = acc(1, ad, d, ln);
		mwr(ad, d, ln);
		tick();
	endtask

	// Read: data driven after the second edge, released after the third
	task automatic rd(int p, logic [17:0] ad);
		nx[p] = acc(0, ad, '0, 4'h0);
		tick();
		tick();
		tick();
		chk(data_oe_n[p], 1'b0);
		chk(data_out[p], mem[ad]);
		tick();
		chk(data_oe_n[p], 1'b1);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hang guard: the whole sequence needs far fewer cycles
	initial begin
		repeat (3000) @(posedge clock);
		bad_count++;
		final_report();
	end

	// Main sequence
	initial begin
		bad_count = 0;
		check_count = 0;
		rst_b = 1'b0;
		output_gate_n = 2'b00;
		nx[0] = idle_req();
		nx[1] = idle_req();
		drive();
		void'($urandom(32'h89d9f0bf));
		repeat (3) @(posedge clock);
		#1;
		rst_b = 1'b1;
		chk({data_oe_n, address_oe_n, wrap_flag_n, mailbox_flag_n}, 8'hFF);
		$display("test reset done");
		// Back-to-back writes, partial lanes, random addresses on both ports
		for (int i = 0; i < 8; i++) begin
			a = 18'($urandom) & 18'h0FFFF;
			wr(i % 2, a, 36'({$urandom, $urandom}), 4'h0);
			wr(i % 2, a, 36'({$urandom, $urandom}), 4'($urandom));
			tick();
			rd(i % 2, a);
		end
		$display("test random access done");
		// High select low blocks the read; then gate raised mid-cycle
		nx[0] = acc(0, a, '0, 4'h0);
		nx[0].hi = 1'b0;
		tick();
		tick();
		tick();
		chk(data_oe_n[0], 1'b1);
		nx[0] = acc(0, a, '0, 4'h0);
		tick();
		tick();
		tick();
		#20 output_gate_n[0] = 1'b1;
		#1 chk(data_oe_n[0], 1'b1);
		tick();
		output_gate_n[0] = 1'b0;
		$display("test select and gate done");
		// Write right after a read with gate low is dropped, then rewritten
		wr(0, 18'h00100, 36'h111111111, 4'h0);
		tick();
		nx[0] = acc(0, 18'h00100, '0, 4'h0);
		tick();
		nx[0] = acc(1, 18'h00100, 36'h2AAAAAAAA, 4'h0);
		tick();
		// Held write completes; host floats, so the pins still carry read data
		nx[0] = acc(1, 18'h00100, '0, 4'h0);
		nx[0].d_en = 1'b0;
		mwr(18'h00100, 36'h111111111, 4'h0);
		tick();
		tick();
		chk(data_oe_n[0], 1'b1);
		tick();
		rd(0, 18'h00100);
		wr(0, 18'h00100, 36'h2AAAAAAAA, 4'h0);
		tick();
		rd(0, 18'h00100);
		$display("test turnaround done");
		// Counter clear shares its cycle with a write
		nx[1] = acc(1, 18'h01234, 36'h0C0FFEE00, 4'h0);
		nx[1].clr_n = 1'b0;
		mwr(0, 36'h0C0FFEE00, 4'h0);
		tick();
		tick();
		rd(1, 18'h00000);
		// Left writes while right reads the same word
		nx[0] = acc(1, 18'h00055, 36'h987654321, 4'h0);
		nx[1] = acc(0, 18'h00055, '0, 4'h0);
		mwr(18'h00055, 36'h987654321, 4'h0);
		tick();
		tick();
		tick();
		chk(data_out[1], 36'h987654321);
		tick();
		$display("test clear and collision done");
		// Mailbox set by the writer, cleared by the other port reading it
		for (int p = 0; p < 2; p++) begin
			wr(p, 18'h3FFFF - 18'(p), 36'h05A5A5A5A, 4'h0);
			tick();
			tick();
			chk(mailbox_flag_n[1-p], 1'b0);
			rd(1 - p, 18'h3FFFF - 18'(p));
			chk(mailbox_flag_n[1-p], 1'b1);
		end
		$display("test mailbox done");
		// Two-bit wrap mask, load, then increments read back each time
		nx[0] = ctl(0, 0, 0, 18'h00003, 0);
		tick();
		nx[0] = ctl(0, 0, 1, 18'h00011, 0);
		tick();
		tick();
		chk(wrap_flag_n[0], 1'b1);
		exp_cnt = 18'h00011;
		for (int i = 0; i < 4; i++) begin
			nx[0] = ctl(1, 0, 1, '0, 0);
			tick();
			nx[0] = ctl(0, 1, 1, '0, 1);
			tick();
			tick();
			exp_cnt = (exp_cnt[1:0] == 2'b11) ? 18'h00011 : exp_cnt + 18'h1;
			chk(wrap_flag_n[0], exp_cnt[1:0] != 2'b11);
			chk(address_oe_n[0], 1'b0);
			chk(address_out[0], exp_cnt);
		end
		nx[0] = ctl(0, 1, 0, '0, 1);
		tick();
		tick();
		chk(address_out[0], 18'h00003);
		tick();
		chk(address_oe_n[0], 1'b1);
		$display("test counter wrap done");
		final_report();
	end
endmodule // test_dual_port_sram_port_logic
